// File: hw/lpta_defines.vh
`ifndef LPTA_DEFINES_VH
`define LPTA_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LPTA_OFF_CTRL      12'h000
`define LPTA_OFF_OSC_CFG   12'h004
`define LPTA_OFF_TIMER     12'h008
`define LPTA_OFF_ALARM     12'h00C
`define LPTA_OFF_STATUS    12'h010
`define LPTA_OFF_MASK      12'h014
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define LPTA_CTRL_RUN      0
`define LPTA_CTRL_ALM_EN   1
`define LPTA_CTRL_AUTO_RST 2
`define LPTA_CTRL_OSC_EN   3
// ----------------------------------------
// Oscillator config field positions
// ----------------------------------------
`define LPTA_OCF_CRYSTAL_MODE_SELECT     0
`define LPTA_OCF_BIAS2     1
`define LPTA_OCF_LFO_EN    2
`define LPTA_OCF_LOAD_LO   4
`define LPTA_OCF_LOAD_HI   7
// ----------------------------------------
// Status bits
// ----------------------------------------
`define LPTA_ST_ALARM      0
`define LPTA_ST_WRAP       1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LPTA_RST_CTRL      4'h0
`define LPTA_RST_OCF       8'h00
`define LPTA_RST_WORD      32'h0000_0000
// ----------------------------------------
// Timing: nominal oscillator periods in ns, system clock period in ns
// ----------------------------------------
`define LPTA_CLK_PERIOD_NS 40
`define LPTA_SELF_LO_NS    50000
`define LPTA_SELF_HI_NS    25000
`define LPTA_LFO_NS        61035
`endif

// File: hw/lpta_osc.v
`timescale 1ns/10ps
`include "lpta_defines.vh"
// Models the oscillator as a tick enable divided from clk; no settling time
module lpta_osc #(
    parameter SELF_LO_DIV = `LPTA_SELF_LO_NS / `LPTA_CLK_PERIOD_NS,
    parameter SELF_HI_DIV = `LPTA_SELF_HI_NS / `LPTA_CLK_PERIOD_NS,
    parameter LFO_DIV     = `LPTA_LFO_NS / `LPTA_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Configuration
    input  wire        osc_en,
    input  wire        crystal_mode_select,
    input  wire        bias_double_select,
    input  wire        low_freq_osc_enable,
    // Timebase
    output reg         tick,
    output wire        lfo_active,
    output wire        pins_shorted
);
    reg  [15:0] cnt_r;
    wire [15:0] div;
    wire        running;

    assign lfo_active   = low_freq_osc_enable;
    assign pins_shorted = osc_en & ~low_freq_osc_enable & ~crystal_mode_select;
    assign running      = low_freq_osc_enable | (osc_en & ~crystal_mode_select);
    assign div = low_freq_osc_enable ? LFO_DIV[15:0] :
                 (bias_double_select ? SELF_HI_DIV[15:0] : SELF_LO_DIV[15:0]);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else if (!running) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else if (cnt_r >= div - 16'h0001) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule

// File: hw/lpta_timer.v
`timescale 1ns/10ps
`include "lpta_defines.vh"
module lpta_timer #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Control
    input  wire             tick,
    input  wire             run,
    input  wire             step2,
    input  wire             alarm_en,
    input  wire             auto_rst,
    input  wire             load,
    input  wire [WIDTH-1:0] load_val,
    input  wire [WIDTH-1:0] match_val,
    // Results
    output reg  [WIDTH-1:0] count,
    output wire             alarm_hit,
    output wire             wrap_hit
);
    wire [WIDTH-1:0] inc;
    wire [WIDTH:0]   sum;

    assign inc       = step2 ? {{(WIDTH-2){1'b0}}, 2'b10} : {{(WIDTH-1){1'b0}}, 1'b1};
    assign sum       = {1'b0, count} + {1'b0, inc};
    assign wrap_hit  = run & tick & sum[WIDTH];
    assign alarm_hit = alarm_en & run & (count == match_val);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {WIDTH{1'b0}};
        end else if (load) begin
            count <= load_val;
        end else if (alarm_hit && auto_rst) begin
            count <= {WIDTH{1'b0}};
        end else if (run && tick) begin
            count <= sum[WIDTH-1:0];
        end
    end
endmodule

// File: hw/lpta_top.v
// How it works
// - Self-oscillate mode (mode select 0) shorts the two crystal pins and needs no parts.
// - In self-oscillate mode bias-double 0 gives about 20 kHz and 1 about 40 kHz.
// - Self-oscillate mode starts ticking at once, with no settling wait.
// - Setting the low-frequency oscillator enable turns it on, selects it, and starts it.
// - With the low-frequency oscillator selected each tick adds to timer bit 1.
// - The 32-bit timer wraps modulo 2^32 (all ones to zero, or 0xFFFFFFFE to zero with the low-frequency oscillator) and keeps counting.
// - The alarm value is a 32-bit unsigned value compared directly with the timer.
// - In auto-reset mode the timer clears to zero after each alarm match.
`timescale 1ns/10ps
`include "lpta_defines.vh"
module lpta_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // AXI4-Lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Oscillator pins and status
    output wire        crystal_short,
    output wire [3:0]  load_cap,
    output wire        irq
);
    localparam [1:0] RESP_OK  = 2'b00;
    localparam [1:0] RESP_ERR = 2'b10;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [3:0]  ctrl_r;
    reg  [7:0]  ocf_r;
    reg  [31:0] alarm_r;
    reg  [1:0]  status_r;
    reg  [1:0]  mask_r;
    reg  [11:0] awaddr_r;
    reg         aw_have_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         w_have_r;
    reg  [31:0] load_val_r;
    reg         load_r;

    wire        tick;
    wire        lfo_active;
    wire [31:0] count;
    wire        alarm_hit;
    wire        wrap_hit;
    wire        wr_fire;
    wire        alm_en;

    // Byte-lane merge shared by the timer and alarm words; the other words use byte lane 0 only
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // ----------------------------------------
    // Oscillator and timer
    // ----------------------------------------
    lpta_osc u_osc (
        .clk                 (clk),
        .rst_n               (rst_n),
        .osc_en              (ctrl_r[`LPTA_CTRL_OSC_EN]),
        .crystal_mode_select (ocf_r[`LPTA_OCF_CRYSTAL_MODE_SELECT]),
        .bias_double_select  (ocf_r[`LPTA_OCF_BIAS2]),
        .low_freq_osc_enable (ocf_r[`LPTA_OCF_LFO_EN]),
        .tick                (tick),
        .lfo_active          (lfo_active),
        .pins_shorted        (crystal_short)
    );

    assign alm_en = ctrl_r[`LPTA_CTRL_ALM_EN];

    lpta_timer #(
        .WIDTH (32)
    ) u_timer (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (tick),
        .run       (ctrl_r[`LPTA_CTRL_RUN]),
        .step2     (lfo_active),
        .alarm_en  (alm_en),
        .auto_rst  (ctrl_r[`LPTA_CTRL_AUTO_RST]),
        .load      (load_r),
        .load_val  (load_val_r),
        .match_val (alarm_r),
        .count     (count),
        .alarm_hit (alarm_hit),
        .wrap_hit  (wrap_hit)
    );

    // Load field is only driven out; trimming is left to software
    assign load_cap = ocf_r[`LPTA_OCF_LOAD_HI:`LPTA_OCF_LOAD_LO];

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
    assign wr_fire       = aw_have_r & w_have_r & ~s_axi_bvalid;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awaddr_r     <= 12'h000;
            aw_have_r    <= 1'b0;
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OK;
            ctrl_r       <= `LPTA_RST_CTRL;
            ocf_r        <= `LPTA_RST_OCF;
            alarm_r      <= `LPTA_RST_WORD;
            mask_r       <= 2'b00;
            status_r     <= 2'b00;
            load_r       <= 1'b0;
            load_val_r   <= `LPTA_RST_WORD;
        end else begin
            load_r <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r  <= s_axi_awaddr;
                aw_have_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
                w_have_r <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Status: write one to clear, but a new event in the same cycle wins
            if (wr_fire && awaddr_r == `LPTA_OFF_STATUS && wstrb_r[0]) begin
                status_r <= (status_r & ~wdata_r[1:0]) |
                            {wrap_hit, alarm_hit};
            end else begin
                status_r <= status_r | {wrap_hit, alarm_hit};
            end
            if (wr_fire) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OK;
                case (awaddr_r)
                    `LPTA_OFF_CTRL: begin
                        if (wstrb_r[0]) begin
                            ctrl_r <= wdata_r[3:0];
                        end
                    end
                    `LPTA_OFF_OSC_CFG: begin
                        if (wstrb_r[0]) begin
                            ocf_r <= wdata_r[7:0];
                        end
                    end
                    `LPTA_OFF_TIMER: begin
                        load_val_r <= merge(count, wdata_r, wstrb_r);
                        load_r     <= 1'b1;
                    end
                    `LPTA_OFF_ALARM: begin
                        alarm_r <= merge(alarm_r, wdata_r, wstrb_r);
                    end
                    `LPTA_OFF_STATUS: begin
                    end
                    `LPTA_OFF_MASK: begin
                        if (wstrb_r[0]) begin
                            mask_r <= wdata_r[1:0];
                        end
                    end
                    default: begin
                        s_axi_bresp <= RESP_ERR;
                    end
                endcase
            end
        end
    end

    // Wrap flag is the only overflow record; no high-order count is kept
    assign irq = |(status_r & mask_r);

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OK;
            case (s_axi_araddr)
                `LPTA_OFF_CTRL:    s_axi_rdata <= {28'h000_0000, ctrl_r};
                `LPTA_OFF_OSC_CFG: s_axi_rdata <= {24'h00_0000, ocf_r};
                `LPTA_OFF_TIMER:   s_axi_rdata <= count;
                `LPTA_OFF_ALARM:   s_axi_rdata <= alarm_r;
                `LPTA_OFF_STATUS:  s_axi_rdata <= {30'h0000_0000, status_r};
                `LPTA_OFF_MASK:    s_axi_rdata <= {30'h0000_0000, mask_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_ERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// File: verif/lpta_properties.sv
`timescale 1ns/10ps
module lpta_props (
    // Clock and reset
    input wire        clk,
    input wire        rst_n,
    // Bus handshakes
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Pins
    input wire        crystal_short,
    input wire [3:0]  load_cap,
    input wire        irq
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_error_zero: assert property (s_axi_rvalid && s_axi_rresp != 2'b00
        |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("bad error read");
    a_pins_by_write:
        assert property ($changed({crystal_short, load_cap}) |-> $rose(s_axi_bvalid))
        else $error("pins changed without a write");
    a_reset_quiet:
        assert property ($rose(rst_n) |-> !irq && !crystal_short && load_cap == 4'h0)
        else $error("outputs not idle after reset");

    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind lpta_top lpta_props u_props (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .crystal_short, .load_cap, .irq);

// File: verif/testbench.sv
`timescale 1ns/10ps
`include "lpta_defines.vh"
module testbench;
    logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, v, v1, a, lc;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  r;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         crystal_short, irq;
    wire  [3:0]  load_cap;
    int          bad_count, n_tests, cyc, m, i, c0, c1, st, ovf;

    lpta_top DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crystal_short,
        .load_cap, .irq);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic [31:0] f_step(input int md);
        return (md == 2) ? 32'h0000_0002 : 32'h0000_0001;
    endfunction
    function automatic int f_per(input int md);
        return md == 0 ? `LPTA_SELF_LO_NS / `LPTA_CLK_PERIOD_NS :
               md == 1 ? `LPTA_SELF_HI_NS / `LPTA_CLK_PERIOD_NS :
                         `LPTA_LFO_NS / `LPTA_CLK_PERIOD_NS;
    endfunction
    task automatic check(input string nm, input [31:0] seen, input [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic hang;
        bad_count++;
        $display("CHECK FAILED wait expected done seen timeout");
        finish_test;
    endtask
    // Ready is looked at on the falling edge, so the decision never races the rising edge
    task automatic wr(input [11:0] ad, input [31:0] d, output [1:0] rs);
        logic aw, w, b;
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        repeat (50) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w  = s_axi_wvalid && s_axi_wready;
            b  = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                // Let an edge pass so the next call never re-raises bready in this step
                @(posedge clk);
                return;
            end
        end
        hang;
    endtask
    task automatic rd(input [11:0] ad, output [31:0] d, output [1:0] rs);
        logic ar, rv;
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        repeat (50) begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            d  = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rv) begin
                s_axi_rready <= 1'b0;
                @(posedge clk);
                return;
            end
        end
        hang;
    endtask
    task automatic tchg(input [31:0] old, output [31:0] nv, output int c);
        logic [1:0] rr;
        repeat (1000) begin
            rd(`LPTA_OFF_TIMER, nv, rr);
            c = cyc;
            if (nv !== old) return;
        end
        hang;
    endtask
    task automatic wirq;
        repeat (3000) begin
            @(negedge clk);
            if (irq === 1'b1) begin
                @(posedge clk);
                return;
            end
        end
        hang;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hF;
        {bad_count, n_tests, cyc, ovf} = 0;
        void'($urandom(18844));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 6; i++) begin
            rd(12'(i * 4), v, r);
            check("reset value", v, 32'h0000_0000);
        end
        rd(12'h018, v, r);
        check("unmapped read", {v[29:0], r}, 32'h0000_0002);
        wr(12'h01C, $urandom, r);
        check("unmapped write", {30'h0, r}, 32'h0000_0002);
        $display("test registers done");
        for (m = 0; m < 3; m++) begin
            lc = $urandom % 16;
            wr(`LPTA_OFF_OSC_CFG, {24'h0, lc[3:0], 1'b0, m == 2, m == 1, 1'b0}, r);
            st = cyc;
            wr(`LPTA_OFF_CTRL, 32'h0000_0009, r);
            check("crystal short", crystal_short, m != 2);
            check("load cap", load_cap, lc);
            wr(`LPTA_OFF_TIMER, -f_step(m), r);
            tchg(-f_step(m), v, c0);
            check("wrap", v, 32'h0000_0000);
            check("first tick", c0 - st < f_per(m) + 40, 1);
            tchg(v, v1, c1);
            check("step", v1 - v, f_step(m));
            check("period", c1 - c0 > f_per(m) - 8 && c1 - c0 < f_per(m) + 8, 1);
            rd(`LPTA_OFF_STATUS, v, r);
            check("wrap flag", v, 32'h0000_0002);
            ovf += v[1];
            wr(`LPTA_OFF_STATUS, 32'h0000_0003, r);
        end
        check("overflow count", ovf, 3);
        $display("test timebase done");
        wr(`LPTA_OFF_OSC_CFG, 32'h0000_0002, r);
        wr(`LPTA_OFF_MASK, 32'h0000_0001, r);
        for (i = 0; i < 3; i++) begin
            a = (i == 0) ? 32'h0000_0000 : $urandom;
            // Stop the timer so no tick lands between the load and the flag clear
            wr(`LPTA_OFF_CTRL, 32'h0000_0000, r);
            wr(`LPTA_OFF_ALARM, a, r);
            wr(`LPTA_OFF_TIMER, a - 1, r);
            wr(`LPTA_OFF_STATUS, 32'h0000_0003, r);
            wr(`LPTA_OFF_CTRL, (i == 2) ? 32'h0000_000F : 32'h0000_000B, r);
            check("irq cleared", irq, 0);
            wirq;
            rd(`LPTA_OFF_TIMER, v, r);
            check("timer at alarm", v, (i == 2) ? 32'h0000_0000 : a);
            rd(`LPTA_OFF_STATUS, v, r);
            check("alarm flag", v, {30'h0, a == 0, 1'b1});
            wr(`LPTA_OFF_MASK, 32'h0000_0000, r);
            check("irq masked", irq, 0);
            wr(`LPTA_OFF_MASK, 32'h0000_0001, r);
            check("irq unmasked", irq, 1);
        end
        $display("test alarm done");
        // Repeated alarms: perpetual adds the interval, auto-reset writes it once
        for (m = 0; m < 2; m++) begin
            a = 32'h0000_0003;
            wr(`LPTA_OFF_CTRL, 32'h0000_0000, r);
            wr(`LPTA_OFF_ALARM, a, r);
            wr(`LPTA_OFF_TIMER, 32'h0000_0000, r);
            wr(`LPTA_OFF_STATUS, 32'h0000_0003, r);
            wr(`LPTA_OFF_CTRL, (m == 1) ? 32'h0000_000F : 32'h0000_000B, r);
            for (i = 0; i < 2; i++) begin
                wirq;
                rd(`LPTA_OFF_TIMER, v, r);
                check("repeat alarm", v, (m == 1) ? 32'h0000_0000 : a);
                if (m == 0) begin
                    a = a + 32'h0000_0003;
                    wr(`LPTA_OFF_ALARM, a, r);
                end
                wr(`LPTA_OFF_STATUS, 32'h0000_0003, r);
            end
        end
        $display("test repeat alarm done");
        finish_test;
    end
endmodule
